// ---- include/wbm_pkg.sv ----
// Shared constants, types and helper functions of the word block move executor
package wbm_pkg;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_COPY = 8'h70;
  localparam logic [7:0] OP_FILL = 8'h71;
  localparam logic [7:0] OP_SWAP = 8'h73;
  localparam logic [7:0] OP_WORD_DISTRIBUTE = 8'h80;

  // ----------------------------------------------------------------
  // Operand limits, compared as BCD
  // ----------------------------------------------------------------
  localparam logic [15:0] COPY_MAX  = 16'h2000;
  localparam logic [15:0] WORD_DISTRIBUTE_MAX  = 16'h6655;
  localparam logic [3:0]  STACK_DIG = 4'h9;

  // ----------------------------------------------------------------
  // Data area map, word addresses
  // ----------------------------------------------------------------
  localparam int          NAREA          = 4;
  localparam logic [2:0]  AREA_NONE      = 3'h7;
  localparam logic [15:0] AREA_LO [NAREA] = '{16'h0000, 16'h1000, 16'h2000, 16'h3800};
  localparam logic [15:0] AREA_HI [NAREA] = '{16'h0fff, 16'h1fff, 16'h37ff, 16'h3fff};
  localparam logic [16:0] DM_LO          = 17'h02000;
  localparam logic [16:0] DM_HI          = 17'h037ff;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_prq  = 9'h002,
    st_pwt  = 9'h004,
    st_chk  = 9'h008,
    st_rd   = 9'h010,
    st_rwt  = 9'h020,
    st_wr   = 9'h040,
    st_drn  = 9'h080,
    st_fin  = 9'h100
  } wbm_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_bcd(input logic [15:0] v);
    is_bcd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[4*i+:4] > 4'h9) begin
        is_bcd = 1'b0;
      end
    end
  endfunction

  function automatic logic [15:0] bcd2bin(input logic [15:0] v);
    bcd2bin = 16'(v[15:12]) * 16'h03e8 + 16'(v[11:8]) * 16'h0064 + 16'(v[7:4]) * 16'h000a + 16'(v[3:0]);
  endfunction

  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[4*i+:4] == 4'h9) begin
          r[4*i+:4] = 4'h0;
        end else begin
          r[4*i+:4] = r[4*i+:4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    bcd_inc = r;
  endfunction

  function automatic logic [2:0] area_of(input logic [16:0] x);
    area_of = AREA_NONE;
    for (int i = 0; i < NAREA; i++) begin
      if (!x[16] && x[15:0] >= AREA_LO[i] && x[15:0] <= AREA_HI[i]) begin
        area_of = 3'(i);
      end
    end
  endfunction

  function automatic logic same_area(input logic [16:0] x, input logic [16:0] y);
    same_area = (area_of(x) == area_of(y)) && (area_of(x) != AREA_NONE);
  endfunction

endpackage

// ---- logic/wbm_exec.sv ----
// Word block move executor: fill, copy, swap and distribute over a word memory
//
// Overview of operation
// - Execution condition off: nothing is written, no error.
// - Fill writes the source value to every word from start through end.
// - Fill flags error when ends lie in different areas or start exceeds end.
// - Indirect pointer not BCD or beyond data memory area flags error.
// - Copy writes source words at offsets 0..N to destination offsets 0..N.
// - Copy flags error when count is not BCD within 0000 to 2000.
// - Copy flags error when either block spans two data areas.
// - Swap exchanges the contents of its two words.
// - Distribute with control 0000..6655 writes source to base plus control.
// - Stack write stores source at base plus pointer plus one, then pointer increments by one.
// - Distribute flags error when control is not BCD or between 6655 and 9000.
`timescale 1ns/1ps
module wbm_exec #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic [7:0]    cmd_code,
  input  wire logic          cmd_exec,
  input  wire logic [DW-1:0] cmd_value,
  input  wire logic [DW-1:0] cmd_count,
  input  wire logic [AW-1:0] cmd_addr_a,
  input  wire logic [AW-1:0] cmd_addr_b,
  input  wire logic          cmd_ind_a,
  input  wire logic          cmd_ind_b,
  output logic               done,
  output logic               error_flag,
  output logic               mem_rd_en,
  output logic [AW-1:0]      mem_rd_addr,
  input  wire logic          mem_rd_valid,
  input  wire logic [DW-1:0] mem_rd_data,
  output logic               mem_wr_valid,
  input  wire logic          mem_wr_ready,
  output logic [AW-1:0]      mem_wr_addr,
  output logic [DW-1:0]      mem_wr_data
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DW != 16 || AW != 16) begin : g_bad_width
    $error("wbm_exec serves four-digit words and 16-bit addresses only");
  end

  wbm_pkg::wbm_state_t st, next_st;
  logic [7:0]  op, next_op;
  logic [15:0] val, next_val, cnt, next_cnt, a, next_a, b, next_b;
  logic [15:0] idx, next_idx, last, next_last, t0, next_t0, t1, next_t1;
  logic        ind_b, next_ind_b, psel, next_psel, ph, next_ph, stk, next_stk;
  logic        err, next_err, next_done, next_flag, next_rd_en;
  logic [15:0] next_rd_addr;
  logic        wpush, wrdy;
  logic [15:0] w_addr, w_data;
  logic        chk_err;
  logic [16:0] end_a, end_b, ptr_abs;

  // ----------------------------------------------------------------
  // Operand checks
  // ----------------------------------------------------------------
  always_comb begin
    chk_err = 1'b0;
    end_a   = {1'b0, a};
    end_b   = {1'b0, b};
    case (op)
      wbm_pkg::OP_FILL: begin
        chk_err = !wbm_pkg::same_area(end_a, end_b) || (a > b);
      end
      wbm_pkg::OP_COPY: begin
        end_a   = {1'b0, a} + {1'b0, wbm_pkg::bcd2bin(cnt)};
        end_b   = {1'b0, b} + {1'b0, wbm_pkg::bcd2bin(cnt)};
        chk_err = !wbm_pkg::is_bcd(cnt) || (cnt > wbm_pkg::COPY_MAX);
        chk_err = chk_err || !wbm_pkg::same_area({1'b0, a}, end_a) || !wbm_pkg::same_area({1'b0, b}, end_b);
      end
      wbm_pkg::OP_SWAP: begin
        chk_err = 1'b0;
      end
      wbm_pkg::OP_WORD_DISTRIBUTE: begin
        if (!wbm_pkg::is_bcd(cnt)) begin
          chk_err = 1'b1;
        end else if (cnt <= wbm_pkg::WORD_DISTRIBUTE_MAX) begin
          end_a   = {1'b0, a} + {1'b0, wbm_pkg::bcd2bin(cnt)};
          chk_err = !wbm_pkg::same_area({1'b0, a}, end_a);
        end else if (cnt[15:12] == wbm_pkg::STACK_DIG) begin
          end_a   = {1'b0, a} + {1'b0, wbm_pkg::bcd2bin({4'h0, cnt[11:0]})};
          chk_err = !wbm_pkg::same_area({1'b0, a}, end_a);
        end else begin
          chk_err = 1'b1;
        end
      end
      default: chk_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Write word selection
  // ----------------------------------------------------------------
  always_comb begin
    ptr_abs = wbm_pkg::DM_LO + {1'b0, wbm_pkg::bcd2bin(mem_rd_data)};
    w_addr  = a + idx;
    w_data  = val;
    case (op)
      wbm_pkg::OP_COPY: begin
        w_addr = b + idx;
        w_data = t0;
      end
      wbm_pkg::OP_SWAP: begin
        w_addr = ph ? b : a;
        w_data = ph ? t0 : t1;
      end
      wbm_pkg::OP_WORD_DISTRIBUTE: begin
        if (stk) begin
          w_addr = ph ? a : a + wbm_pkg::bcd2bin(t0) + 16'h0001;
          w_data = ph ? wbm_pkg::bcd_inc(t0) : val;
        end else begin
          w_addr = a + wbm_pkg::bcd2bin(cnt);
        end
      end
      default: w_addr = a + idx;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;  next_op = op;  next_val = val;  next_cnt = cnt;
    next_a = a;  next_b = b;  next_idx = idx;  next_last = last;
    next_t0 = t0;  next_t1 = t1;  next_ind_b = ind_b;  next_psel = psel;
    next_ph = ph;  next_stk = stk;  next_err = err;
    next_rd_en = 1'b0;  next_rd_addr = mem_rd_addr;
    wpush = 1'b0;
    case (st)
      wbm_pkg::st_idle: begin
        if (cmd_valid && cmd_ready) begin
          next_op = cmd_code;  next_val = cmd_value;  next_cnt = cmd_count;
          next_a = cmd_addr_a;  next_b = cmd_addr_b;  next_ind_b = cmd_ind_b;
          next_idx = 16'h0000;  next_ph = 1'b0;  next_err = 1'b0;
          next_stk = (cmd_code == wbm_pkg::OP_WORD_DISTRIBUTE) && (cmd_count[15:12] == wbm_pkg::STACK_DIG);
          next_psel = !cmd_ind_a;
          if (!cmd_exec) begin
            next_st = wbm_pkg::st_fin;
          end else if (cmd_ind_a || cmd_ind_b) begin
            next_st = wbm_pkg::st_prq;
          end else begin
            next_st = wbm_pkg::st_chk;
          end
        end
      end
      wbm_pkg::st_prq: begin
        next_rd_en   = 1'b1;
        next_rd_addr = psel ? b : a;
        next_st      = wbm_pkg::st_pwt;
      end
      wbm_pkg::st_pwt: begin
        if (mem_rd_valid) begin
          if (!wbm_pkg::is_bcd(mem_rd_data) || ptr_abs > wbm_pkg::DM_HI) begin
            next_err = 1'b1;
            next_st  = wbm_pkg::st_fin;
          end else begin
            if (psel) begin
              next_b = ptr_abs[15:0];
            end else begin
              next_a = ptr_abs[15:0];
            end
            next_psel = 1'b1;
            next_st   = (!psel && ind_b) ? wbm_pkg::st_prq : wbm_pkg::st_chk;
          end
        end
      end
      wbm_pkg::st_chk: begin
        next_last = (op == wbm_pkg::OP_FILL) ? b - a : wbm_pkg::bcd2bin(cnt);
        if (chk_err) begin
          next_err = 1'b1;
          next_st  = wbm_pkg::st_fin;
        end else if (op == wbm_pkg::OP_FILL || (op == wbm_pkg::OP_WORD_DISTRIBUTE && !stk)) begin
          next_st = wbm_pkg::st_wr;
        end else begin
          next_st = wbm_pkg::st_rd;
        end
      end
      wbm_pkg::st_rd: begin
        next_rd_en   = 1'b1;
        next_rd_addr = (op == wbm_pkg::OP_COPY) ? a + idx : ((op == wbm_pkg::OP_SWAP && idx[0]) ? b : a);
        next_st      = wbm_pkg::st_rwt;
      end
      wbm_pkg::st_rwt: begin
        if (mem_rd_valid) begin
          if (op == wbm_pkg::OP_SWAP && idx[0]) begin
            next_t1 = mem_rd_data;
            next_st = wbm_pkg::st_wr;
          end else if (op == wbm_pkg::OP_SWAP) begin
            next_t0  = mem_rd_data;
            next_idx = 16'h0001;
            next_st  = wbm_pkg::st_rd;
          end else if (stk && (!wbm_pkg::is_bcd(mem_rd_data) || mem_rd_data >= {4'h0, cnt[11:0]})) begin
            next_err = 1'b1;
            next_st  = wbm_pkg::st_fin;
          end else begin
            next_t0 = mem_rd_data;
            next_st = wbm_pkg::st_wr;
          end
        end
      end
      wbm_pkg::st_wr: begin
        wpush = 1'b1;
        if (wrdy) begin
          if (op == wbm_pkg::OP_SWAP || stk) begin
            next_ph = 1'b1;
            next_st = ph ? wbm_pkg::st_drn : wbm_pkg::st_wr;
          end else if (op == wbm_pkg::OP_WORD_DISTRIBUTE || idx == last) begin
            next_st = wbm_pkg::st_drn;
          end else begin
            next_idx = idx + 16'h0001;
            next_st  = (op == wbm_pkg::OP_COPY) ? wbm_pkg::st_rd : wbm_pkg::st_wr;
          end
        end
      end
      wbm_pkg::st_drn: begin
        if (!mem_wr_valid) begin
          next_st = wbm_pkg::st_fin;
        end
      end
      wbm_pkg::st_fin: next_st = wbm_pkg::st_idle;
      default:         next_st = wbm_pkg::st_idle;
    endcase
    next_done = (next_st == wbm_pkg::st_fin);
    next_flag = next_done ? next_err : error_flag;
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= wbm_pkg::st_idle;  op <= 8'h00;  val <= 16'h0000;  cnt <= 16'h0000;
      a <= 16'h0000;  b <= 16'h0000;  idx <= 16'h0000;  last <= 16'h0000;
      t0 <= 16'h0000;  t1 <= 16'h0000;  ind_b <= 1'b0;  psel <= 1'b0;
      ph <= 1'b0;  stk <= 1'b0;  err <= 1'b0;  done <= 1'b0;  error_flag <= 1'b0;
      cmd_ready <= 1'b0;  mem_rd_en <= 1'b0;  mem_rd_addr <= 16'h0000;
    end else begin
      st <= next_st;  op <= next_op;  val <= next_val;  cnt <= next_cnt;
      a <= next_a;  b <= next_b;  idx <= next_idx;  last <= next_last;
      t0 <= next_t0;  t1 <= next_t1;  ind_b <= next_ind_b;  psel <= next_psel;
      ph <= next_ph;  stk <= next_stk;  err <= next_err;  done <= next_done;
      error_flag <= next_flag;  cmd_ready <= (next_st == wbm_pkg::st_idle);
      mem_rd_en <= next_rd_en;  mem_rd_addr <= next_rd_addr;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  wbm_wr_buf #(
    .W (32)
  ) u_wr_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (wpush),
    .in_ready  (wrdy),
    .in_data   ({w_addr, w_data}),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  ({mem_wr_addr, mem_wr_data})
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  exec_off_a: assert property ((st == wbm_pkg::st_idle) && cmd_valid && cmd_ready && !cmd_exec
    |=> done && !error_flag && !wpush) else $error("disabled operation did work");
  fill_word_a: assert property (wpush && op == wbm_pkg::OP_FILL
    |-> w_data == val && w_addr == a + idx && w_addr <= b) else $error("fill word wrong");
  fill_range_a: assert property ((st == wbm_pkg::st_chk) && op == wbm_pkg::OP_FILL && a > b
    |=> (st == wbm_pkg::st_fin) ##0 (done && error_flag)) else $error("fill range not refused");
  ptr_check_a: assert property ((st == wbm_pkg::st_pwt) && mem_rd_valid && !wbm_pkg::is_bcd(mem_rd_data)
    |=> done && error_flag) else $error("bad pointer not refused");
  copy_word_a: assert property (wpush && op == wbm_pkg::OP_COPY
    |-> w_addr == b + idx && w_data == t0 && idx <= last) else $error("copy word wrong");
  copy_count_a: assert property ((st == wbm_pkg::st_chk) && op == wbm_pkg::OP_COPY && cnt > 16'h2000
    |=> done && error_flag) else $error("copy count not refused");
  copy_area_a: assert property ((st == wbm_pkg::st_chk) && op == wbm_pkg::OP_COPY
    && !wbm_pkg::same_area({1'b0, b}, end_b) |=> error_flag) else $error("copy area not refused");
  swap_pair_a: assert property (wpush && wrdy && op == wbm_pkg::OP_SWAP && !ph
    |-> w_addr == a && w_data == t1 ##1 (wpush && w_addr == b && w_data == t0)) else $error("swap wrong");
  word_distribute_word_a: assert property (wpush && op == wbm_pkg::OP_WORD_DISTRIBUTE && !stk
    |-> w_addr == a + wbm_pkg::bcd2bin(cnt) && w_data == val) else $error("distribute word wrong");
  stack_push_a: assert property (wpush && wrdy && stk && !ph
    |-> w_data == val ##1 (w_addr == a && w_data == wbm_pkg::bcd_inc(t0))) else $error("stack push wrong");
  ctrl_range_a: assert property ((st == wbm_pkg::st_chk) && op == wbm_pkg::OP_WORD_DISTRIBUTE
    && cnt > 16'h6655 && cnt[15:12] != 4'h9 |=> error_flag) else $error("control not refused");
  drain_done_a: assert property (done |-> !mem_wr_valid && !$past(wpush)) else $error("done before writes");

  fill_run_c: cover property (wpush && op == wbm_pkg::OP_FILL && idx == 16'h0002);
  swap_run_c: cover property (done && !error_flag && op == wbm_pkg::OP_SWAP);
  stack_run_c: cover property (done && !error_flag && stk);
  stall_c: cover property (wpush && !wrdy);

endmodule

// ---- logic/wbm_wr_buf.sv ----
// Two-entry write buffer between the sequencer and the data memory port
`timescale 1ns/1ps
module wbm_wr_buf #(
  parameter int W = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (W < 2) begin : g_bad_width
    $error("wbm_wr_buf width too small");
  end

  logic [W-1:0] slot1;
  logic [1:0]   cnt;
  logic [W-1:0] next_slot0;
  logic [W-1:0] next_slot1;
  logic [1:0]   next_cnt;
  logic         push;
  logic         pop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    in_ready   = (cnt != 2'h2);
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    next_slot0 = out_data;
    next_slot1 = slot1;
    next_cnt   = cnt;
    if (pop) begin
      next_slot0 = slot1;
      next_cnt   = next_cnt - 2'h1;
    end
    if (push) begin
      if (next_cnt == 2'h0) begin
        next_slot0 = in_data;
      end else begin
        next_slot1 = in_data;
      end
      next_cnt = next_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data  <= '0;
      slot1     <= '0;
      cnt       <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      out_data  <= next_slot0;
      slot1     <= next_slot1;
      cnt       <= next_cnt;
      out_valid <= (next_cnt != 2'h0);
    end
  end

endmodule

// ---- test/wbm_mem_model.sv ----
// Behavioural word memory facing the executor's read and write ports
`timescale 1ns/1ps
module wbm_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        mem_rd_en,
  input  wire logic [15:0] mem_rd_addr,
  output logic             mem_rd_valid,
  output logic [15:0]      mem_rd_data,
  input  wire logic        mem_wr_valid,
  output logic             mem_wr_ready,
  input  wire logic [15:0] mem_wr_addr,
  input  wire logic [15:0] mem_wr_data
);
  logic [15:0] mem [0:65535];
  logic [15:0] rd_a;
  logic [1:0]  rd_wait;
  logic        rd_pend;
  logic [1:0]  tick;
  // ----------------------------------------------------------------
  // Slow mode delays reads and takes one write in four cycles
  // ----------------------------------------------------------------
  assign mem_wr_ready = !slow || (tick == 2'h3);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend      <= 1'b0;
      rd_wait      <= 2'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 16'h0000;
      tick         <= 2'h0;
    end else begin
      tick         <= tick + 2'h1;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd_en) begin
        rd_pend <= 1'b1;
        rd_a    <= mem_rd_addr;
        rd_wait <= slow ? 2'h2 : 2'h0;
      end else if (rd_pend && rd_wait != 2'h0) begin
        rd_wait <= rd_wait - 2'h1;
      end else if (rd_pend) begin
        mem_rd_valid <= 1'b1;
        mem_rd_data  <= mem[rd_a];
        rd_pend      <= 1'b0;
      end
      if (mem_wr_valid && mem_wr_ready) begin
        mem[mem_wr_addr] <= mem_wr_data;
      end
    end
  end
endmodule

// ---- test/word_block_move_executor_test.sv ----
// Self-checking testbench of the word block move executor
`timescale 1ns/1ps
module word_block_move_executor_test;
  logic        sys_clk, rst_n, slow, cmd_valid, cmd_ready, cmd_exec, cmd_ind_a, cmd_ind_b;
  logic        done, error_flag, mem_rd_en, mem_rd_valid, mem_wr_valid, mem_wr_ready;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_value, cmd_count, cmd_addr_a, cmd_addr_b;
  logic [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  int          n_fail, checks, n_wr, cyc, i;

  wbm_exec DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_exec(cmd_exec), .cmd_value(cmd_value), .cmd_count(cmd_count),
    .cmd_addr_a(cmd_addr_a), .cmd_addr_b(cmd_addr_b), .cmd_ind_a(cmd_ind_a), .cmd_ind_b(cmd_ind_b),
    .done(done), .error_flag(error_flag), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  wbm_mem_model MEM (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data));

  // ----------------------------------------------------------------
  // Clock, write counter and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) n_wr++;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      test_done;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task cmd(input logic [7:0] c, input logic ex, input logic [15:0] v, n, a, b,
           input logic [1:0] ind, input logic e, input int w);
    int k;
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge sys_clk) #2;
    {cmd_code, cmd_exec, cmd_value, cmd_count} = {c, ex, v, n};
    {cmd_addr_a, cmd_addr_b, cmd_ind_b, cmd_ind_a} = {a, b, ind};
    cmd_valid = 1'b1;
    n_wr = 0;
    @(posedge sys_clk) #2;
    cmd_valid = 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(posedge sys_clk) #2;
    chk({15'h0000, done}, 16'h0001);
    chk({15'h0000, error_flag}, {15'h0000, e});
    chk(16'(n_wr), 16'(w));
  endtask

  task test_done;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_off;
    logic [7:0] ops [4];
    ops = '{wbm_pkg::OP_COPY, wbm_pkg::OP_FILL, wbm_pkg::OP_SWAP, wbm_pkg::OP_WORD_DISTRIBUTE};
    MEM.mem[16'h0400] = 16'h1234;
    for (i = 0; i < 4; i++) cmd(ops[i], 1'b0, 16'hffff, 16'h0000, 16'h0400, 16'h0401, 2'b00, 1'b0, 0);
    chk(MEM.mem[16'h0400], 16'h1234);
  endtask

  task t_fill;
    slow = 1'b1;
    for (i = 16'h10; i < 16'h18; i++) MEM.mem[i] = 16'h0000;
    cmd(wbm_pkg::OP_FILL, 1'b1, 16'habcd, 16'h0000, 16'h0011, 16'h0016, 2'b00, 1'b0, 6);
    for (i = 16'h11; i < 16'h17; i++) chk(MEM.mem[i], 16'habcd);
    chk(MEM.mem[16'h0010] | MEM.mem[16'h0017], 16'h0000);
    cmd(wbm_pkg::OP_FILL, 1'b1, 16'h0001, 16'h0000, 16'h0013, 16'h0013, 2'b00, 1'b0, 1);
    cmd(wbm_pkg::OP_FILL, 1'b1, 16'h0001, 16'h0000, 16'h0012, 16'h0011, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_FILL, 1'b1, 16'h0001, 16'h0000, 16'h0fff, 16'h1000, 2'b00, 1'b1, 0);
  endtask

  task t_copy;
    slow = 1'b0;
    for (i = 0; i < 16'h07d1; i++) MEM.mem[i] = 16'(i);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0003, 16'h0100, 16'h2000, 2'b00, 1'b0, 4);
    for (i = 0; i < 4; i++) chk(MEM.mem[16'h2000 + i], 16'h0100 + 16'(i));
    chk(MEM.mem[16'h0103], 16'h0103);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h2000, 16'h0000, 16'h2800, 2'b00, 1'b0, 2001);
    chk(MEM.mem[16'h2fd0], 16'h07d0);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h2001, 16'h0000, 16'h2800, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h00a0, 16'h0000, 16'h2800, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0002, 16'h0ffe, 16'h2800, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0003, 16'h0000, 16'h1ffe, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0001, 16'h2000, 16'h3000, 2'b00, 1'b0, 2);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0001, 16'h0104, 16'h2000, 2'b00, 1'b0, 2);
    cmd(wbm_pkg::OP_COPY, 1'b1, 16'h0000, 16'h0001, 16'h3000, 16'h0104, 2'b00, 1'b0, 2);
    chk(MEM.mem[16'h2001], 16'h0105);
    chk(MEM.mem[16'h0105], 16'h0101);
  endtask

  task t_swap;
    slow = 1'b1;
    {MEM.mem[16'h0200], MEM.mem[16'h0201], MEM.mem[16'h0202]} = {16'h1111, 16'h2222, 16'h4444};
    cmd(wbm_pkg::OP_SWAP, 1'b1, 16'h0000, 16'h0000, 16'h0200, 16'h0201, 2'b00, 1'b0, 2);
    chk(MEM.mem[16'h0200], 16'h2222);
    chk(MEM.mem[16'h0201], 16'h1111);
    {MEM.mem[16'h0050], MEM.mem[16'h0051], MEM.mem[16'h0052]} = {16'h0005, 16'h00a0, 16'h6144};
    MEM.mem[16'h2005] = 16'h3333;
    cmd(wbm_pkg::OP_SWAP, 1'b1, 16'h0000, 16'h0000, 16'h0202, 16'h0050, 2'b10, 1'b0, 2);
    chk(MEM.mem[16'h2005], 16'h4444);
    chk(MEM.mem[16'h0202], 16'h3333);
    cmd(wbm_pkg::OP_SWAP, 1'b1, 16'h0000, 16'h0000, 16'h0202, 16'h0051, 2'b10, 1'b1, 0);
    cmd(wbm_pkg::OP_SWAP, 1'b1, 16'h0000, 16'h0000, 16'h0052, 16'h0202, 2'b01, 1'b1, 0);
  endtask

  task t_word_distribute;
    slow = 1'b0;
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h7777, 16'h0012, 16'h0300, 16'h0000, 2'b00, 1'b0, 1);
    chk(MEM.mem[16'h030c], 16'h7777);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h7777, 16'h0020, 16'h0ff0, 16'h0000, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h7777, 16'h6656, 16'h0000, 16'h0000, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h7777, 16'h8999, 16'h0000, 16'h0000, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h7777, 16'h00a0, 16'h0000, 16'h0000, 2'b00, 1'b1, 0);
    {MEM.mem[16'h2100], MEM.mem[16'h2200]} = {16'h0000, 16'h0009};
    for (i = 0; i < 3; i++) begin
      cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h5a50 + 16'(i), 16'h9003, 16'h2100, 16'h0000, 2'b00, 1'b0, 2);
    end
    for (i = 0; i < 3; i++) chk(MEM.mem[16'h2101 + i], 16'h5a50 + 16'(i));
    chk(MEM.mem[16'h2100], 16'h0003);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'h5a5f, 16'h9003, 16'h2100, 16'h0000, 2'b00, 1'b1, 0);
    cmd(wbm_pkg::OP_WORD_DISTRIBUTE, 1'b1, 16'hbeef, 16'h9012, 16'h2200, 16'h0000, 2'b00, 1'b0, 2);
    chk(MEM.mem[16'h220a], 16'hbeef);
    chk(MEM.mem[16'h2200], 16'h0010);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, slow, cmd_valid, cmd_exec, cmd_ind_a, cmd_ind_b, cmd_code} = '0;
    {cmd_value, cmd_count, cmd_addr_a, cmd_addr_b} = '0;
    {n_fail, checks, n_wr, cyc} = '0;
    repeat (4) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    t_off;
    t_fill;
    t_copy;
    t_swap;
    t_word_distribute;
    test_done;
  end
endmodule
